// ---- sim/lfb_bridge_checker.sv ----
/*
  Port-level timing checks for the flash bridge.
  Assumes one mclk domain with a synchronous active-high reset.
*/
`timescale 1ns/10ps
module lfb_bridge_checker (
  input wire logic       mclk,
  input wire logic       reset,
  input wire logic       cfgRead,
  input wire logic [7:0] cfgIndex,
  input wire logic [7:0] cfgRdata,
  input wire logic       ioWrite,
  input wire logic       ioHit,
  input wire logic       memRead,
  input wire logic       memDone,
  input wire logic       hostReady,
  input wire logic       cmdBusy,
  input wire logic       spiPinsEnable,
  input wire logic       spiClk,
  input wire logic       flash_chip_enable_n
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  // A host read takes 325 cycles, too long for a plain delay, so a counter tracks its age.
  localparam int MEM_LAT = 325;
  int memAge;
  always_ff @(posedge mclk) begin
    if (reset) begin
      memAge <= 0;
    end else if (memRead && hostReady && !ioWrite) begin
      memAge <= 1;
    end else if (memAge == MEM_LAT) begin
      memAge <= 0;
    end else if (memAge != 0) begin
      memAge <= memAge + 1;
    end
  end

  property p_mem_lat;
    memAge == MEM_LAT |-> memDone;
  endproperty
  a_mem_lat: assert property (p_mem_lat) else $error("memory read latency wrong");
  property p_ce_busy;
    cmdBusy != flash_chip_enable_n;
  endproperty
  a_ce_busy: assert property (p_ce_busy) else $error("chip enable not tied to busy");
  property p_clk_idle;
    flash_chip_enable_n |-> !spiClk;
  endproperty
  a_clk_idle: assert property (p_clk_idle) else $error("flash clock runs idle");
  property p_clk_high;
    $rose(spiClk) |-> spiClk [*4] ##1 !spiClk;
  endproperty
  a_clk_high: assert property (p_clk_high) else $error("flash clock high phase");
  property p_busy_refuse;
    ioWrite && cmdBusy |=> !ioHit;
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("write taken while busy");
  property p_pins_off;
    !spiPinsEnable |-> !hostReady && !ioHit;
  endproperty
  a_pins_off: assert property (p_pins_off) else $error("bridge active with strap low");
  property p_strap;
    cfgRead && cfgIndex == 8'h24 && spiPinsEnable |=> cfgRdata == 8'h02;
  endproperty
  a_strap: assert property (p_strap) else $error("strap status bit wrong");
  property p_done_ready;
    memDone |-> hostReady && !cmdBusy && flash_chip_enable_n;
  endproperty
  a_done_ready: assert property (p_done_ready) else $error("not idle at done");
endmodule : lfb_bridge_checker

// ---- sim/lfb_flash_model.sv ----
/*
  Behavioural serial flash in clock mode 0: logs every byte it is sent and
  answers with a fixed byte pattern indexed by position in the frame.
  Assumes the bench clears the log before each frame.
*/
`timescale 1ns/10ps
module lfb_flash_model (
  input  wire logic spiClk,
  input  wire logic chipEnableN,
  input  wire logic spiMosi,
  output logic      spiMiso
);
  logic [7:0] seen [$];
  logic [7:0] shiftIn;
  int         bitCount;

  function automatic logic outBit(input int n);
    logic [7:0] b;
    b = 8'h5a + 8'(17 * (n / 8));
    return b[7 - n % 8];
  endfunction : outBit

  initial begin
    spiMiso = 1'b1;
    bitCount = 0;
  end
  always @(negedge chipEnableN) begin
    bitCount = 0;
    spiMiso = outBit(0);
  end
  // A released line shows the inverse so a stale bit is never mistaken for data.
  always @(posedge chipEnableN) begin
    spiMiso = ~spiMiso;
  end
  always @(posedge spiClk) begin
    if (!chipEnableN) begin
      shiftIn = {shiftIn[6:0], spiMosi};
      bitCount++;
      if (bitCount % 8 == 0) seen.push_back(shiftIn);
    end
  end
  always @(negedge spiClk) begin
    if (!chipEnableN) spiMiso = outBit(bitCount);
  end
endmodule : lfb_flash_model

// ---- sim/tb_lfb_bridge.sv ----
/*
  Self-checking bench for the flash bridge; a mode table and queues predict each frame.
  Assumes the flash model of lfb_flash_model.sv and the checker bound at the foot.
*/
`timescale 1ns/10ps
module tb_lfb_bridge;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic        strapPin = 1'b0;
  logic        cfgWrite = 1'b0;
  logic        cfgRead = 1'b0;
  logic [7:0]  cfgDevice = 8'h06;
  logic [7:0]  cfgIndex = 8'h00;
  logic [7:0]  cfgWdata = 8'h00;
  logic        ioWrite = 1'b0;
  logic        ioRead = 1'b0;
  logic [15:0] ioAddr = 16'h0000;
  logic [7:0]  ioWdata = 8'h00;
  logic        memRead = 1'b0;
  logic [23:0] memAddr = 24'h000000;
  logic [7:0]  cfgRdata, ioRdata, memRdata;
  logic        ioHit, memDone, hostReady, cmdBusy, spiPinsEnable;
  logic        spiClk, flash_chip_enable_n, spiMosi, spiMiso;
  int          bad_count = 0;
  int          check_count = 0;
  logic [31:0] seed = 32'd21;
  logic [15:0] base = 16'h0000;
  int          tA [12] = '{0, 0, 0, 0, 1, 1, 1, 1, 1, 1, 1, 1};
  int          tD [12] = '{0, 0, 0, 0, 0, 0, 0, 1, 0, 0, 0, 0};
  int          tW [12] = '{0, 0, 1, 0, 0, 1, 4, 0, 0, 0, 0, 0};
  int          tR [12] = '{0, 0, 0, 2, 0, 0, 0, 4, 1, 2, 3, 4};

  always #10 mclk = ~mclk;

  lfb_bridge dut (.mclk(mclk), .reset(reset), .strapPin(strapPin), .cfgWrite(cfgWrite),
    .cfgRead(cfgRead), .cfgDevice(cfgDevice), .cfgIndex(cfgIndex), .cfgWdata(cfgWdata),
    .cfgRdata(cfgRdata), .ioWrite(ioWrite), .ioRead(ioRead), .ioAddr(ioAddr),
    .ioWdata(ioWdata), .ioRdata(ioRdata), .ioHit(ioHit), .memRead(memRead),
    .memAddr(memAddr), .memRdata(memRdata), .memDone(memDone), .hostReady(hostReady),
    .cmdBusy(cmdBusy), .spiPinsEnable(spiPinsEnable), .spiClk(spiClk),
    .flash_chip_enable_n(flash_chip_enable_n), .spiMosi(spiMosi), .spiMiso(spiMiso));
  lfb_flash_model fl (.spiClk(spiClk), .chipEnableN(flash_chip_enable_n),
    .spiMosi(spiMosi), .spiMiso(spiMiso));

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd

  function automatic logic [7:0] pat(input int n);
    return 8'h5a + 8'(17 * n);
  endfunction : pat

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  task automatic acc(input bit io, input bit wr, input logic [15:0] a, input logic [7:0] d,
                     output logic [7:0] q, output logic hit);
    @(posedge mclk);
    if (io) begin
      ioWrite <= wr;
      ioRead <= !wr;
      ioAddr <= base + a;
    end else begin
      cfgWrite <= wr;
      cfgRead <= !wr;
      cfgIndex <= a[7:0];
    end
    ioWdata <= d;
    cfgWdata <= d;
    @(posedge mclk);
    {ioWrite, ioRead, cfgWrite, cfgRead} <= 4'h0;
    #1;
    q = io ? ioRdata : cfgRdata;
    hit = ioHit;
  endtask : acc

  // Waits for idle (0), a memory read done (1) or host ready (2).
  task automatic await(input int w);
    int n;
    for (n = 0; n < 2000; n++) begin
      @(posedge mclk);
      #1;
      if ((w == 0 && cmdBusy === 1'b0) || (w == 1 && memDone === 1'b1)) break;
      if (w == 2 && hostReady === 1'b1) break;
    end
    if (n == 2000) begin
      bad_count++;
      stop_test();
    end
  endtask : await

  initial begin
    logic [7:0]  q, op, nib, mid, low;
    logic [7:0]  d [4];
    logic        hit;
    logic [7:0]  tx [$];
    logic [23:0] ma;
    int          m, k;
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    repeat (12) @(posedge mclk);
    #1;
    chk("pins enable strap low", 1'b0, spiPinsEnable);
    acc(0, 0, 16'h0024, 8'h00, q, hit);
    chk("strap status low", 8'h00, q);
    acc(1, 1, 16'h0000, 8'h11, q, hit);
    chk("window hit strap low", 1'b0, hit);
    @(posedge mclk);
    reset <= 1'b1;
    strapPin <= 1'b1;
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    await(2);
    acc(0, 0, 16'h0024, 8'h00, q, hit);
    chk("strap status high", 8'h02, q);
    base = {rnd(), rnd()};
    acc(0, 1, 16'h0062, base[15:8], q, hit);
    acc(0, 1, 16'h0063, base[7:0], q, hit);
    @(posedge mclk);
    cfgDevice <= 8'h07;
    acc(0, 1, 16'h0062, ~base[15:8], q, hit);
    @(posedge mclk);
    cfgDevice <= 8'h06;
    acc(0, 0, 16'h0062, 8'h00, q, hit);
    chk("base high", base[15:8], q);
    acc(0, 0, 16'h0063, 8'h00, q, hit);
    chk("base low", base[7:0], q);
    acc(1, 1, 16'h0008, 8'h5a, q, hit);
    chk("hit above window", 1'b0, hit);
    acc(1, 1, 16'hffff, 8'h5a, q, hit);
    chk("hit below window", 1'b0, hit);
    for (m = 0; m < 2; m++) begin
      acc(1, 1, 16'h0001, {m ? 4'hc : 4'h0, 4'h9}, q, hit);
      acc(1, 0, 16'h0001, 8'h00, q, hit);
      chk("idle mode write", 9'h009, {cmdBusy, q});
    end
    $display("test setup done");
    for (m = 1; m < 12; m++) begin
      op = rnd();
      nib = rnd() & 8'h0f;
      mid = rnd();
      low = rnd();
      acc(1, 1, 16'h0000, op, q, hit);
      acc(1, 1, 16'h0002, mid, q, hit);
      acc(1, 1, 16'h0003, low, q, hit);
      for (k = 0; k < 4; k++) begin
        d[k] = rnd();
        acc(1, 1, 16'(4 + k), d[k], q, hit);
      end
      fl.seen.delete();
      acc(1, 1, 16'h0001, {4'(m), nib[3:0]}, q, hit);
      chk("start hit", 2'b11, {hit, cmdBusy});
      if (m == 6) begin
        acc(1, 1, 16'h0000, ~op, q, hit);
        chk("write while busy", 1'b0, hit);
      end
      await(0);
      tx = '{op};
      if (tA[m] == 1) tx = {tx, nib, mid, low};
      if (tD[m] == 1) tx.push_back(8'h00);
      for (k = 0; k < tW[m]; k++) tx.push_back(d[k]);
      chk("frame bytes", tx.size() + tR[m], fl.seen.size());
      for (k = 0; k < tx.size(); k++) chk("sent byte", tx[k], fl.seen[k]);
      acc(1, 0, 16'h0001, 8'h00, q, hit);
      chk("mode cleared", nib, q);
      acc(1, 0, 16'h0000, 8'h00, q, hit);
      chk("opcode kept", op, q);
      for (k = 0; k < 4; k++) begin
        acc(1, 0, 16'(4 + k), 8'h00, q, hit);
        chk("data byte", k < tR[m] ? pat(tx.size() + k) : d[k], q);
      end
      $display("test mode %0h done", m);
    end
    ma = {rnd(), rnd(), rnd()};
    fl.seen.delete();
    @(posedge mclk);
    memRead <= 1'b1;
    memAddr <= ma;
    @(posedge mclk);
    memRead <= 1'b0;
    await(1);
    chk("memory read data", pat(4), memRdata);
    tx = '{lfb_pkg::MEM_READ_OPCODE, ma[23:16], ma[15:8], ma[7:0]};
    for (k = 0; k < 4; k++) chk("memory frame byte", tx[k], fl.seen[k]);
    $display("test memory read done");
    stop_test();
  end
endmodule : tb_lfb_bridge

bind lfb_bridge lfb_bridge_checker chk_i (.mclk(mclk), .reset(reset), .cfgRead(cfgRead),
  .cfgIndex(cfgIndex), .cfgRdata(cfgRdata), .ioWrite(ioWrite), .ioHit(ioHit),
  .memRead(memRead), .memDone(memDone), .hostReady(hostReady), .cmdBusy(cmdBusy),
  .spiPinsEnable(spiPinsEnable), .spiClk(spiClk),
  .flash_chip_enable_n(flash_chip_enable_n));

// ---- src/lfb_bridge.sv ----
/*
  Host to serial flash bridge: memory reads pass through as flash reads, and
  an eight-byte I/O window lets software run shaped flash transactions.
  Assumes the host bus is already decoded into single-cycle strobes on mclk
  and that the flash works in clock mode 0.
*/
`timescale 1ns/10ps

// Notes on behaviour
// - Flash pins act as bridge only when the strap samples high.
// - Sampled strap state reads at bit 1 of configuration register 24h.
// - Host memory reads become serial read opcode, address, then returned byte.
// - Eight consecutive I/O bytes from the base address reach the command registers.
// - Window base comes from device 6 registers 62h high and 63h low.
// - Offset 0 holds the opcode, always sent first.
// - Offset 1 holds mode in bits 7:4 and address 19:16 in 3:0.
// - Offsets 2,3 hold address 15:8, 7:0; offsets 4-7 hold data bytes.
// - Software loads fields first; writing the mode starts the transaction.
// - Mode 1 sends the opcode only.
// - Mode 2 sends opcode and data byte zero.
// - Mode 3 sends opcode then receives two bytes.
// - Mode 4 sends opcode and three address bytes.
// - Mode 5 sends opcode, address and data byte zero.
// - Mode 6 sends opcode, address and four data bytes.
module lfb_bridge
  import lfb_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        strapPin,
  input  wire logic        cfgWrite,
  input  wire logic        cfgRead,
  input  wire logic [7:0]  cfgDevice,
  input  wire logic [7:0]  cfgIndex,
  input  wire logic [7:0]  cfgWdata,
  output logic      [7:0]  cfgRdata,
  input  wire logic        ioWrite,
  input  wire logic        ioRead,
  input  wire logic [15:0] ioAddr,
  input  wire logic [7:0]  ioWdata,
  output logic      [7:0]  ioRdata,
  output logic             ioHit,
  input  wire logic        memRead,
  input  wire logic [23:0] memAddr,
  output logic      [7:0]  memRdata,
  output logic             memDone,
  output logic             hostReady,
  output logic             cmdBusy,
  output logic             spiPinsEnable,
  output logic             spiClk,
  output logic             flash_chip_enable_n,
  output logic             spiMosi,
  input  wire logic        spiMiso
);

  logic [2:0]  strapSync,  next_strapSync;
  logic [1:0]  settleCnt,  next_settleCnt;
  logic        settled,    next_settled;
  logic        bridgeEnable, next_bridgeEnable;
  logic [2:0]  misoSync,   next_misoSync;
  logic        misoLevel,  next_misoLevel;

  logic [7:0]  windowBaseHigh, next_windowBaseHigh;
  logic [7:0]  windowBaseLow,  next_windowBaseLow;
  logic [7:0]  flashOpcode,    next_flashOpcode;
  logic [3:0]  modeField,      next_modeField;
  logic [3:0]  addrUpperNibble, next_addrUpperNibble;
  logic [7:0]  addrMiddle,     next_addrMiddle;
  logic [7:0]  addrLow,        next_addrLow;
  logic [7:0]  dataByte [0:3];
  logic [7:0]  next_dataByte [0:3];

  lfb_state_t  state,      next_state;
  logic [71:0] txBuf,      next_txBuf;
  logic [6:0]  rxShift,    next_rxShift;
  logic [6:0]  bitCnt,     next_bitCnt;
  logic [6:0]  txBits,     next_txBits;
  logic [6:0]  totalBits,  next_totalBits;
  logic [7:0]  divCnt,     next_divCnt;
  logic        hostOrigin, next_hostOrigin;

  logic [7:0]  next_cfgRdata;
  logic [7:0]  next_ioRdata;
  logic        next_ioHit;
  logic [7:0]  next_memRdata;
  logic        next_memDone;
  logic        next_hostReady;
  logic        next_cmdBusy;
  logic        next_spiClk;
  logic        next_chipEnableN;
  logic        next_spiMosi;

  logic [15:0] windowBase;
  logic [15:0] windowOffset;
  logic        windowHit;
  logic [2:0]  offset;

  assign windowBase   = {windowBaseHigh, windowBaseLow};
  assign windowOffset = ioAddr - windowBase;
  assign windowHit    = bridgeEnable && (windowOffset < WINDOW_BYTES);
  assign offset       = windowOffset[2:0];

  always_comb begin
    logic [8:0]  plan;
    logic [71:0] build;
    logic [3:0]  nBytes;
    logic [23:0] flashAddr;
    logic        startCmd;
    logic        startMem;
    logic [7:0]  rxByte;
    logic [6:0]  rxBit;
    plan      = lfb_mode_plan(ioWdata[7:4]);
    build     = 72'h0;
    nBytes    = 4'h0;
    flashAddr = {4'h0, ioWdata[3:0], addrMiddle, addrLow};
    startCmd  = 1'b0;
    startMem  = 1'b0;
    rxByte    = {rxShift, misoLevel};
    rxBit     = bitCnt - txBits;

    next_strapSync      = {strapSync[1:0], strapPin};
    next_settleCnt      = settleCnt;
    next_settled        = settled;
    next_bridgeEnable   = bridgeEnable;
    next_misoSync       = {misoSync[1:0], spiMiso};
    next_misoLevel      = misoLevel;
    next_windowBaseHigh = windowBaseHigh;
    next_windowBaseLow  = windowBaseLow;
    next_flashOpcode    = flashOpcode;
    next_modeField      = modeField;
    next_addrUpperNibble = addrUpperNibble;
    next_addrMiddle     = addrMiddle;
    next_addrLow        = addrLow;
    for (int i = 0; i < 4; i++) begin
      next_dataByte[i] = dataByte[i];
    end
    next_state       = state;
    next_txBuf       = txBuf;
    next_rxShift     = rxShift;
    next_bitCnt      = bitCnt;
    next_txBits      = txBits;
    next_totalBits   = totalBits;
    next_divCnt      = divCnt;
    next_hostOrigin  = hostOrigin;
    next_cfgRdata    = 8'h00;
    next_ioRdata     = 8'h00;
    next_ioHit       = 1'b0;
    next_memRdata    = memRdata;
    next_memDone     = 1'b0;
    next_spiClk      = spiClk;
    next_chipEnableN = flash_chip_enable_n;
    next_spiMosi     = spiMosi;

    // The strap is caught once, after its synchroniser has filled and settled.
    if (!settled) begin
      if (settleCnt == 2'(STRAP_SETTLE_CYCLES - 1) && strapSync[1] == strapSync[2]) begin
        next_bridgeEnable = strapSync[2];
        next_settled      = 1'b1;
      end else if (settleCnt != 2'(STRAP_SETTLE_CYCLES - 1)) begin
        next_settleCnt = settleCnt + 2'h1;
      end
    end
    if (misoSync[1] == misoSync[2]) begin
      next_misoLevel = misoSync[2];
    end

    if (cfgWrite && cfgDevice == CFG_DEVICE_FLASH) begin
      if (cfgIndex == CFG_BASE_HIGH) begin
        next_windowBaseHigh = cfgWdata;
      end else if (cfgIndex == CFG_BASE_LOW) begin
        next_windowBaseLow = cfgWdata;
      end
    end
    if (cfgRead) begin
      if (cfgIndex == CFG_STRAP_STATUS) begin
        next_cfgRdata[STRAP_STATUS_BIT] = bridgeEnable;
      end else if (cfgDevice == CFG_DEVICE_FLASH && cfgIndex == CFG_BASE_HIGH) begin
        next_cfgRdata = windowBaseHigh;
      end else if (cfgDevice == CFG_DEVICE_FLASH && cfgIndex == CFG_BASE_LOW) begin
        next_cfgRdata = windowBaseLow;
      end
    end

    if (ioRead && windowHit) begin
      next_ioHit = 1'b1;
      case (offset)
        OFS_OPCODE:   next_ioRdata = flashOpcode;
        OFS_MODE:     next_ioRdata = {modeField, addrUpperNibble};
        OFS_ADDR_MID: next_ioRdata = addrMiddle;
        OFS_ADDR_LOW: next_ioRdata = addrLow;
        default:      next_ioRdata = dataByte[offset[1:0]];
      endcase
    end

    // Writes are refused while a transaction runs, so its fields cannot shift under it.
    if (ioWrite && windowHit && state == ST_IDLE) begin
      next_ioHit = 1'b1;
      case (offset)
        OFS_OPCODE:   next_flashOpcode = ioWdata;
        OFS_MODE: begin
          next_addrUpperNibble = ioWdata[3:0];
          if (plan[8]) begin
            next_modeField = ioWdata[7:4];
            startCmd       = 1'b1;
          end
        end
        OFS_ADDR_MID: next_addrMiddle = ioWdata;
        OFS_ADDR_LOW: next_addrLow = ioWdata;
        default:      next_dataByte[offset[1:0]] = ioWdata;
      endcase
    end else if (memRead && hostReady) begin
      startMem = 1'b1;
    end

    if (startCmd) begin
      build[71 -: 8] = flashOpcode;
      nBytes = 4'h1;
      if (plan[7]) begin
        build[63 -: 24] = flashAddr;
        nBytes = 4'h4;
      end
      if (plan[6]) begin
        nBytes = nBytes + 4'h1;
      end
      for (int i = 0; i < 4; i++) begin
        if (3'(i) < plan[5:3]) begin
          build[71 - 8 * (int'(nBytes) + i) -: 8] = dataByte[i];
        end
      end
      nBytes = nBytes + {1'b0, plan[5:3]};
      next_txBits     = {nBytes, 3'h0};
      next_totalBits  = {nBytes + {1'b0, plan[2:0]}, 3'h0};
      next_hostOrigin = 1'b0;
    end else if (startMem) begin
      build[71 -: 32] = {MEM_READ_OPCODE, memAddr};
      next_txBits     = 7'd32;
      next_totalBits  = 7'd40;
      next_hostOrigin = 1'b1;
    end
    if (startCmd || startMem) begin
      next_txBuf       = build;
      next_spiMosi     = build[71];
      next_bitCnt      = 7'h0;
      next_divCnt      = 8'h0;
      next_spiClk      = 1'b0;
      next_chipEnableN = 1'b0;
      next_state       = ST_SHIFT;
    end

    case (state)
      ST_IDLE: begin
      end
      ST_SHIFT: begin
        if (divCnt == 8'(SCK_HALF_CYCLES - 1)) begin
          next_divCnt = 8'h0;
          next_spiClk = ~spiClk;
          // The slow clock leaves time for the three-stage input path to settle,
          // so the input is taken on the falling edge rather than the rising one.
          if (spiClk) begin
            next_rxShift = rxByte[6:0];
            if (bitCnt >= txBits && bitCnt[2:0] == 3'h7) begin
              if (hostOrigin) begin
                next_memRdata = rxByte;
              end else begin
                next_dataByte[rxBit[4:3]] = rxByte;
              end
            end
            if (bitCnt == totalBits - 7'h1) begin
              next_state = ST_END;
            end else begin
              next_bitCnt  = bitCnt + 7'h1;
              next_txBuf   = {txBuf[70:0], 1'b0};
              next_spiMosi = txBuf[70];
            end
          end
        end else begin
          next_divCnt = divCnt + 8'h1;
        end
      end
      ST_END: begin
        // Hold chip enable a half period past the last edge before releasing it.
        if (divCnt == 8'(SCK_HALF_CYCLES - 1)) begin
          next_divCnt      = 8'h0;
          next_chipEnableN = 1'b1;
          next_spiMosi     = 1'b0;
          next_state       = ST_IDLE;
          if (hostOrigin) begin
            next_memDone = 1'b1;
          end else begin
            next_modeField = MODE_IDLE;
          end
        end else begin
          next_divCnt = divCnt + 8'h1;
        end
      end
      default: begin
        next_state       = ST_IDLE;
        next_chipEnableN = 1'b1;
      end
    endcase

    next_cmdBusy   = next_state != ST_IDLE;
    next_hostReady = next_bridgeEnable && next_state == ST_IDLE;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      strapSync           <= 3'h0;
      settleCnt           <= 2'h0;
      settled             <= 1'b0;
      bridgeEnable        <= 1'b0;
      misoSync            <= 3'h0;
      misoLevel           <= 1'b0;
      windowBaseHigh      <= BASE_RESET;
      windowBaseLow       <= BASE_RESET;
      flashOpcode         <= BYTE_RESET;
      modeField           <= MODE_IDLE;
      addrUpperNibble     <= 4'h0;
      addrMiddle          <= BYTE_RESET;
      addrLow             <= BYTE_RESET;
      for (int i = 0; i < 4; i++) begin
        dataByte[i] <= BYTE_RESET;
      end
      state               <= ST_IDLE;
      txBuf               <= 72'h0;
      rxShift             <= 7'h0;
      bitCnt              <= 7'h0;
      txBits              <= 7'h0;
      totalBits           <= 7'h0;
      divCnt              <= 8'h0;
      hostOrigin          <= 1'b0;
      cfgRdata            <= 8'h00;
      ioRdata             <= 8'h00;
      ioHit               <= 1'b0;
      memRdata            <= 8'h00;
      memDone             <= 1'b0;
      hostReady           <= 1'b0;
      cmdBusy             <= 1'b0;
      spiPinsEnable       <= 1'b0;
      spiClk              <= 1'b0;
      flash_chip_enable_n <= 1'b1;
      spiMosi             <= 1'b0;
    end else begin
      strapSync           <= next_strapSync;
      settleCnt           <= next_settleCnt;
      settled             <= next_settled;
      bridgeEnable        <= next_bridgeEnable;
      misoSync            <= next_misoSync;
      misoLevel           <= next_misoLevel;
      windowBaseHigh      <= next_windowBaseHigh;
      windowBaseLow       <= next_windowBaseLow;
      flashOpcode         <= next_flashOpcode;
      modeField           <= next_modeField;
      addrUpperNibble     <= next_addrUpperNibble;
      addrMiddle          <= next_addrMiddle;
      addrLow             <= next_addrLow;
      for (int i = 0; i < 4; i++) begin
        dataByte[i] <= next_dataByte[i];
      end
      state               <= next_state;
      txBuf               <= next_txBuf;
      rxShift             <= next_rxShift;
      bitCnt              <= next_bitCnt;
      txBits              <= next_txBits;
      totalBits           <= next_totalBits;
      divCnt              <= next_divCnt;
      hostOrigin          <= next_hostOrigin;
      cfgRdata            <= next_cfgRdata;
      ioRdata             <= next_ioRdata;
      ioHit               <= next_ioHit;
      memRdata            <= next_memRdata;
      memDone             <= next_memDone;
      hostReady           <= next_hostReady;
      cmdBusy             <= next_cmdBusy;
      spiPinsEnable       <= next_bridgeEnable;
      spiClk              <= next_spiClk;
      flash_chip_enable_n <= next_chipEnableN;
      spiMosi             <= next_spiMosi;
    end
  end

endmodule : lfb_bridge

// ---- src/lfb_pkg.sv ----
/*
  Constants, state type and mode decoding shared by the flash bridge.
  Assumes a 50 MHz system clock and a host interface already decoded into
  configuration, I/O and memory read strobes.
*/
package lfb_pkg;

  localparam int CLK_PERIOD_NS      = 20;
  localparam int SCK_HALF_NS        = 80;
  localparam int SCK_HALF_CYCLES    = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STRAP_SETTLE_CYCLES = 3;

  localparam logic [2:0] OFS_OPCODE   = 3'h0;
  localparam logic [2:0] OFS_MODE     = 3'h1;
  localparam logic [2:0] OFS_ADDR_MID = 3'h2;
  localparam logic [2:0] OFS_ADDR_LOW = 3'h3;

  localparam logic [15:0] WINDOW_BYTES = 16'h0008;

  localparam logic [7:0] CFG_STRAP_STATUS = 8'h24;
  localparam int         STRAP_STATUS_BIT = 1;
  localparam logic [7:0] CFG_BASE_HIGH    = 8'h62;
  localparam logic [7:0] CFG_BASE_LOW     = 8'h63;
  localparam logic [7:0] CFG_DEVICE_FLASH = 8'h06;
  localparam logic [7:0] BASE_RESET       = 8'h00;
  localparam logic [7:0] BYTE_RESET       = 8'h00;

  localparam logic [7:0] MEM_READ_OPCODE = 8'h03;

  localparam logic [3:0] MODE_IDLE      = 4'h0;
  localparam logic [3:0] MODE_OPCODE    = 4'h1;
  localparam logic [3:0] MODE_PARAM     = 4'h2;
  localparam logic [3:0] MODE_READ_TWO  = 4'h3;
  localparam logic [3:0] MODE_ERASE     = 4'h4;
  localparam logic [3:0] MODE_PROG_ONE  = 4'h5;
  localparam logic [3:0] MODE_PROG_FOUR = 4'h6;
  localparam logic [3:0] MODE_FAST_READ = 4'h7;
  localparam logic [3:0] MODE_READ_ONE  = 4'h8;
  localparam logic [3:0] MODE_READ_2    = 4'h9;
  localparam logic [3:0] MODE_READ_3    = 4'ha;
  localparam logic [3:0] MODE_READ_4    = 4'hb;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_END   = 2'b10
  } lfb_state_t;

  // Plan bits: valid, address, dummy, data bytes sent (3), data bytes received (3).
  function automatic logic [8:0] lfb_mode_plan(input logic [3:0] mode);
    case (mode)
      MODE_OPCODE:    lfb_mode_plan = 9'b1_0_0_000_000;
      MODE_PARAM:     lfb_mode_plan = 9'b1_0_0_001_000;
      MODE_READ_TWO:  lfb_mode_plan = 9'b1_0_0_000_010;
      MODE_ERASE:     lfb_mode_plan = 9'b1_1_0_000_000;
      MODE_PROG_ONE:  lfb_mode_plan = 9'b1_1_0_001_000;
      MODE_PROG_FOUR: lfb_mode_plan = 9'b1_1_0_100_000;
      MODE_FAST_READ: lfb_mode_plan = 9'b1_1_1_000_100;
      MODE_READ_ONE:  lfb_mode_plan = 9'b1_1_0_000_001;
      MODE_READ_2:    lfb_mode_plan = 9'b1_1_0_000_010;
      MODE_READ_3:    lfb_mode_plan = 9'b1_1_0_000_011;
      MODE_READ_4:    lfb_mode_plan = 9'b1_1_0_000_100;
      default:        lfb_mode_plan = 9'b0_0_0_000_000;
    endcase
  endfunction : lfb_mode_plan

endpackage : lfb_pkg
